/* cfi_params.svh */
`ifndef CFI_PARAMS_SVH
`define CFI_PARAMS_SVH

`define CFI_ADDR_FAULT_ONE 8'h27
`define CFI_ADDR_MASK_ZERO 8'h28
`define CFI_ADDR_MASK_ONE 8'h29

`define CFI_RST_FAULT_ONE 8'h00
`define CFI_RST_MASK_ZERO 8'h00
`define CFI_RST_MASK_ONE 8'h00

`define CFI_WMASK_MASK_ZERO 8'hFF
`define CFI_WMASK_MASK_ONE 8'hD7

`define CFI_BIT_SYS_SHORT 7
`define CFI_BIT_SYS_OV 6
`define CFI_BIT_SRC_OV 5
`define CFI_BIT_SRC_UV 4
`define CFI_BIT_DIE_SHUT 2

`define CFI_BIT_CUR_LIMIT 7
`define CFI_BIT_VOLT_LIMIT 6
`define CFI_BIT_WATCHDOG 5
`define CFI_BIT_WEAK_SRC 4
`define CFI_BIT_PWR_GOOD 3
`define CFI_BIT_IN2_PRES 2
`define CFI_BIT_IN1_PRES 1
`define CFI_BIT_BUS_PRES 0

`define CFI_BIT_CHG_STAT 7
`define CFI_BIT_OPTIMIZER 6
`define CFI_BIT_BUS_STAT 4
`define CFI_BIT_THERM_REG 2
`define CFI_BIT_BAT_PRES 1
`define CFI_BIT_PORT_DET 0

`define CFI_INT_PULSE_CYC 16
`define CFI_INT_GAP_CYC 16
`define CFI_PEND_W 4

`endif

/* cfi_pkg.sv */
package cfi_pkg;

   typedef struct packed {
      logic system_rail_short_fault;
      logic system_rail_overvoltage_fault;
      logic source_mode_overvoltage_fault;
      logic source_mode_undervoltage_fault;
      logic die_thermal_shutdown_fault;
   } cfi_fault_s;

   typedef struct packed {
      logic input_current_limit_state;
      logic source_mode_current_regulation;
      logic input_voltage_limit_state;
      logic source_mode_voltage_regulation;
      logic watchdog_expired;
      logic weak_source;
      logic die_thermal_regulation;
   } cfi_enter_s;

   typedef struct packed {
      logic power_good_indication;
      logic second_input_present;
      logic first_input_present;
      logic input_bus_present;
      logic [2:0] charge_status;
      logic [1:0] input_current_optimizer;
      logic [3:0] input_bus_status;
      logic battery_present;
      logic port_detection_status;
   } cfi_status_s;

   typedef enum logic [2:0] {
      CFI_IDLE = 3'b001,
      CFI_PULSE = 3'b010,
      CFI_GAP = 3'b100
   } cfi_pulse_e;

endpackage

/* cfi_edge_det.sv */
`timescale 1ns/1ns
module cfi_edge_det #(
   parameter int W = 8,
   parameter bit RISE = 1'b1
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] sig_i,
   output logic [W-1:0] evt_o
);
   logic [W-1:0] prev_q;
   logic armed_q;

   // first cycle after reset only primes, so a level already high is no event
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prev_q <= '0;
         armed_q <= 1'b0;
      end else begin
         prev_q <= sig_i;
         armed_q <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         if (RISE) begin : g_rise
            assign evt_o[g] = armed_q & sig_i[g] & ~prev_q[g];
         end else begin : g_chg
            assign evt_o[g] = armed_q & (sig_i[g] ^ prev_q[g]);
         end
      end
   endgenerate
endmodule // cfi_edge_det

/* cfi_int_pulse.sv */
`timescale 1ns/1ns
`include "cfi_params.svh"
module cfi_int_pulse
   import cfi_pkg::*;
#(
   parameter int PULSE_CYC = `CFI_INT_PULSE_CYC,
   parameter int GAP_CYC = `CFI_INT_GAP_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   output logic take_o,
   output logic int_n_o
);
   localparam int CW = $clog2(PULSE_CYC + GAP_CYC + 1);
   cfi_pulse_e state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;

   assign take_o = start_i && (state_q == CFI_IDLE);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         CFI_IDLE: begin
            if (start_i) begin
               state_d = CFI_PULSE;
               cnt_d = CW'(PULSE_CYC - 1);
            end
         end
         CFI_PULSE: begin
            if (cnt_q == '0) begin
               state_d = CFI_GAP;
               cnt_d = CW'(GAP_CYC - 1);
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         CFI_GAP: begin
            // gap keeps back-to-back pulses apart so the host sees each one
            if (cnt_q == '0) begin
               state_d = CFI_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = CFI_IDLE;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= CFI_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         int_n_o <= 1'b1;
      end else begin
         int_n_o <= (state_d != CFI_PULSE);
      end
   end
endmodule // cfi_int_pulse

/* cfi_top.sv */
// Behaviour
// - system short stop sets fault bit 7
// - system overvoltage stop sets fault bit 6
// - source-mode stop on overvoltage sets bit 5
// - source-mode stop on undervoltage sets bit 4
// - die shutdown rising edge sets bit 2
// - fault flags read-only, zero after reset
// - mask0 bit7 gates current-limit entry pulse
// - mask0 bit6 gates voltage-limit entry pulse
// - mask0 bit5 gates watchdog expiry pulse
// - mask0 bit4 gates weak source pulse
// - mask0 bit3 gates power-good toggle pulse
// - mask0 bits2..0 gate presence change pulses
// - mask1 bit7 gates charge status change
// - mask1 bit6 gates optimizer status change
// - mask1 bit4 gates bus status change
// - mask1 bit2 gates thermal regulation entry
// - mask1 bit1 gates battery presence change
// - mask1 bit0 gates port detection change
// - masks read-write, cleared by reset command
`timescale 1ns/1ns
`include "cfi_params.svh"
module cfi_top
   import cfi_pkg::*;
#(
   parameter int PULSE_CYC = `CFI_INT_PULSE_CYC,
   parameter int GAP_CYC = `CFI_INT_GAP_CYC,
   parameter int PEND_W = `CFI_PEND_W
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rst_cmd_i,
   input wire cfi_fault_s fault_i,
   input wire cfi_enter_s enter_i,
   input wire cfi_status_s status_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic int_n_o
);

   // register decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   logic wr_mask0;
   logic wr_mask1;
   logic rd_fault;

   assign wr_mask0 = reg_wr_i && hit(reg_addr_i, `CFI_ADDR_MASK_ZERO);
   assign wr_mask1 = reg_wr_i && hit(reg_addr_i, `CFI_ADDR_MASK_ONE);
   assign rd_fault = reg_rd_i && hit(reg_addr_i, `CFI_ADDR_FAULT_ONE);

   // event detection
   logic [4:0] fault_evt;
   cfi_enter_s enter_evt;
   logic [$bits(cfi_status_s)-1:0] chg_evt;
   cfi_status_s chg_s;

   cfi_edge_det #(
      .W(5),
      .RISE(1'b1)
   ) u_fault_edge (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sig_i(fault_i),
      .evt_o(fault_evt)
   );

   cfi_edge_det #(
      .W($bits(cfi_enter_s)),
      .RISE(1'b1)
   ) u_enter_edge (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sig_i(enter_i),
      .evt_o(enter_evt)
   );

   cfi_edge_det #(
      .W($bits(cfi_status_s)),
      .RISE(1'b0)
   ) u_change_det (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sig_i(status_i),
      .evt_o(chg_evt)
   );

   assign chg_s = cfi_status_s'(chg_evt);

   // fault flag register
   cfi_fault_s fault_evt_s;
   logic [7:0] fault_set;
   logic [7:0] fault_q;
   logic [7:0] fault_d;

   assign fault_evt_s = cfi_fault_s'(fault_evt);

   always_comb begin
      fault_set = 8'h00;
      fault_set[`CFI_BIT_SYS_SHORT] = fault_evt_s.system_rail_short_fault;
      fault_set[`CFI_BIT_SYS_OV] = fault_evt_s.system_rail_overvoltage_fault;
      fault_set[`CFI_BIT_SRC_OV] = fault_evt_s.source_mode_overvoltage_fault;
      fault_set[`CFI_BIT_SRC_UV] = fault_evt_s.source_mode_undervoltage_fault;
      fault_set[`CFI_BIT_DIE_SHUT] = fault_evt_s.die_thermal_shutdown_fault;
   end

   // flags clear when the host reads them; a new fault in that same cycle
   // survives the read so the host never misses it
   always_comb begin
      fault_d = fault_q;
      if (rd_fault) begin
         fault_d = 8'h00;
      end
      fault_d = fault_d | fault_set;
   end

   // host writes never reach this register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fault_q <= `CFI_RST_FAULT_ONE;
      end else begin
         fault_q <= fault_d;
      end
   end

   // mask registers
   logic [7:0] mask0_q;
   logic [7:0] mask1_q;

   // the reset command wins over a write in the same cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mask0_q <= `CFI_RST_MASK_ZERO;
      end else if (reg_rst_cmd_i) begin
         mask0_q <= `CFI_RST_MASK_ZERO;
      end else if (wr_mask0) begin
         mask0_q <= reg_wdata_i & `CFI_WMASK_MASK_ZERO;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mask1_q <= `CFI_RST_MASK_ONE;
      end else if (reg_rst_cmd_i) begin
         mask1_q <= `CFI_RST_MASK_ONE;
      end else if (wr_mask1) begin
         mask1_q <= reg_wdata_i & `CFI_WMASK_MASK_ONE;
      end
   end

   // qualified interrupt events
   logic [13:0] qual;
   logic [13:0] src_evt;
   logic [13:0] src_mask;
   logic ev_cur;
   logic ev_volt;
   logic ev_chg;
   logic ev_opt;
   logic ev_bus;
   logic ev_det;

   assign ev_cur = enter_evt.input_current_limit_state
                 | enter_evt.source_mode_current_regulation;
   assign ev_volt = enter_evt.input_voltage_limit_state
                  | enter_evt.source_mode_voltage_regulation;
   assign ev_chg = |chg_s.charge_status;
   assign ev_opt = |chg_s.input_current_optimizer;
   assign ev_bus = |chg_s.input_bus_status;
   assign ev_det = chg_s.port_detection_status;

   // every source keeps its own line, so unrelated events in one cycle
   // still give one pulse each
   always_comb begin
      src_evt[0] = ev_cur;
      src_evt[1] = ev_volt;
      src_evt[2] = enter_evt.watchdog_expired;
      src_evt[3] = enter_evt.weak_source;
      src_evt[4] = chg_s.power_good_indication;
      src_evt[5] = chg_s.second_input_present;
      src_evt[6] = chg_s.first_input_present;
      src_evt[7] = chg_s.input_bus_present;
      src_evt[8] = ev_chg;
      src_evt[9] = ev_opt;
      src_evt[10] = ev_bus;
      src_evt[11] = enter_evt.die_thermal_regulation;
      src_evt[12] = chg_s.battery_present;
      src_evt[13] = ev_det;
   end

   always_comb begin
      src_mask[0] = mask0_q[`CFI_BIT_CUR_LIMIT];
      src_mask[1] = mask0_q[`CFI_BIT_VOLT_LIMIT];
      src_mask[2] = mask0_q[`CFI_BIT_WATCHDOG];
      src_mask[3] = mask0_q[`CFI_BIT_WEAK_SRC];
      src_mask[4] = mask0_q[`CFI_BIT_PWR_GOOD];
      src_mask[5] = mask0_q[`CFI_BIT_IN2_PRES];
      src_mask[6] = mask0_q[`CFI_BIT_IN1_PRES];
      src_mask[7] = mask0_q[`CFI_BIT_BUS_PRES];
      src_mask[8] = mask1_q[`CFI_BIT_CHG_STAT];
      src_mask[9] = mask1_q[`CFI_BIT_OPTIMIZER];
      src_mask[10] = mask1_q[`CFI_BIT_BUS_STAT];
      src_mask[11] = mask1_q[`CFI_BIT_THERM_REG];
      src_mask[12] = mask1_q[`CFI_BIT_BAT_PRES];
      src_mask[13] = mask1_q[`CFI_BIT_PORT_DET];
   end

   genvar q;
   generate
      for (q = 0; q < 14; q++) begin : g_qual
         assign qual[q] = src_evt[q] & ~src_mask[q];
      end
   endgenerate

   // pending pulse count
   function automatic logic [3:0] ones(input logic [13:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 14; i++) begin
         n = n + {3'b000, v[i]};
      end
      return n;
   endfunction

   localparam int SW = PEND_W + 1;
   logic [PEND_W-1:0] pend_q;
   logic [PEND_W-1:0] pend_d;
   logic [SW-1:0] pend_sum;
   logic take;
   logic [3:0] new_cnt;

   assign new_cnt = ones(qual);

   // events that land while the pin is busy are queued, not merged;
   // the count saturates, which bounds area at the cost of dropping
   // pulses under an extreme burst
   always_comb begin
      pend_sum = SW'(pend_q) + SW'(new_cnt) - SW'(take);
      if (pend_sum > SW'({PEND_W{1'b1}})) begin
         pend_d = {PEND_W{1'b1}};
      end else begin
         pend_d = pend_sum[PEND_W-1:0];
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_d;
      end
   end

   cfi_int_pulse #(
      .PULSE_CYC(PULSE_CYC),
      .GAP_CYC(GAP_CYC)
   ) u_pulse (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(pend_q != '0),
      .take_o(take),
      .int_n_o(int_n_o)
   );

   // read path
   logic [7:0] rdata_d;

   always_comb begin
      rdata_d = 8'h00;
      case (reg_addr_i)
         `CFI_ADDR_FAULT_ONE: begin
            rdata_d = fault_q;
         end
         `CFI_ADDR_MASK_ZERO: begin
            rdata_d = mask0_q;
         end
         `CFI_ADDR_MASK_ONE: begin
            rdata_d = mask1_q & `CFI_WMASK_MASK_ONE;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
      end
   end

endmodule // cfi_top

/* cfi_top_chk.sv */
`timescale 1ns/1ns
module cfi_top_chk
   import cfi_pkg::*;
#(
   parameter int PULSE_CYC = 16,
   parameter int GAP_CYC = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rst_cmd_i,
   input wire cfi_fault_s fault_i,
   input wire cfi_enter_s enter_i,
   input wire cfi_status_s status_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic int_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [7:0] lo_q;
   logic [7:0] hi_q;
   logic rd27;
   logic mapped;
   assign rd27 = reg_rd_i && reg_addr_i == 8'h27;
   assign mapped = reg_addr_i inside {8'h27, 8'h28, 8'h29};
   // high count saturates so a long idle never wraps into a false gap
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lo_q <= 8'h00;
         hi_q <= 8'hFF;
      end else begin
         lo_q <= int_n_o ? 8'h00 : lo_q + 8'h01;
         hi_q <= !int_n_o ? 8'h00 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h01);
      end
   end
   property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
   property p_no_rvalid; !reg_rd_i |=> !reg_rvalid_o; endproperty
   property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
   property p_unmapped; reg_rd_i && !mapped |=> reg_rdata_o == 8'h00; endproperty
   property p_res1;
      reg_rd_i && reg_addr_i == 8'h29 |=> reg_rdata_o[5] == 1'b0 && reg_rdata_o[3] == 1'b0;
   endproperty
   property p_res0; rd27 |=> reg_rdata_o[3] == 1'b0 && reg_rdata_o[1:0] == 2'b00; endproperty
   property p_rdclr;
      (rd27 && $stable(fault_i)) ##1 $stable(fault_i) ##1 (rd27 && $stable(fault_i))
         |=> reg_rdata_o == 8'h00;
   endproperty
   property p_pulse; $rose(int_n_o) |-> lo_q == 8'(PULSE_CYC); endproperty
   property p_gap; $fell(int_n_o) |-> hi_q >= 8'(GAP_CYC); endproperty
   a_rvalid: assert property (p_rvalid) else $error("no read answer");
   a_no_rvalid: assert property (p_no_rvalid) else $error("stray read answer");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_res1: assert property (p_res1) else $error("mask reserved bit set");
   a_res0: assert property (p_res0) else $error("fault reserved bit set");
   a_rdclr: assert property (p_rdclr) else $error("flags kept after read");
   a_pulse: assert property (p_pulse) else $error("bad pulse length");
   a_gap: assert property (p_gap) else $error("pulse gap too short");
   c_pulse: cover property ($fell(int_n_o));
   c_flag: cover property (rd27 ##1 reg_rdata_o != 8'h00);
   c_cmd: cover property (reg_rst_cmd_i);
endmodule // cfi_top_chk

bind cfi_top cfi_top_chk #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) u_chk (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rst_cmd_i(reg_rst_cmd_i),
   .fault_i(fault_i), .enter_i(enter_i), .status_i(status_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .int_n_o(int_n_o)
);

/* cfi_host_model.sv */
`timescale 1ns/1ns
module cfi_host_model (
   input wire logic clk_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic int_n_i,
   output int pulses_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
      pulses_o = 0;
   end
   always @(negedge int_n_i) pulses_o++;
   // idle bus shows inverted values so nothing relies on stale address or data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      d = reg_rdata_i;
      reg_addr_o = ~a;
   endtask
endmodule // cfi_host_model

/* cfi_top_tb.sv */
`timescale 1ns/1ns
module cfi_top_tb
   import cfi_pkg::*;
;
   logic clk_i, sys_rst_i, wr, rd, rst_cmd, rvalid, int_n;
   logic [7:0] addr, wdata, rdata;
   cfi_fault_s flt;
   cfi_enter_s ent;
   cfi_status_s st;
   int pulses, num_errors, tests_run, cyc, n, b;
   int mb1[6] = '{7, 6, 4, 2, 1, 0};
   logic [7:0] fx[5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04};
   cfi_top #(.PULSE_CYC(2), .GAP_CYC(2)) u_dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rst_cmd_i(rst_cmd), .fault_i(flt),
      .enter_i(ent), .status_i(st), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .int_n_o(int_n)
   );
   cfi_host_model u_host (
      .clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata),
      .reg_rdata_i(rdata), .int_n_i(int_n), .pulses_o(pulses)
   );
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d, e);
      chk({7'h00, rvalid}, 8'h01);
   endtask
   // enter events are one-cycle rises; status events are single toggles
   task automatic fire(input int k);
      cfi_enter_s e;
      e = '0;
      @(negedge clk_i);
      case (k)
         0: e.input_current_limit_state = 1'b1;
         1: e.input_voltage_limit_state = 1'b1;
         2: e.watchdog_expired = 1'b1;
         3: e.weak_source = 1'b1;
         4: st.power_good_indication ^= 1'b1;
         5: st.second_input_present ^= 1'b1;
         6: st.first_input_present ^= 1'b1;
         7: st.input_bus_present ^= 1'b1;
         8: st.charge_status ^= 3'h5;
         9: st.input_current_optimizer ^= 2'h3;
         10: st.input_bus_status ^= 4'hF;
         11: e.die_thermal_regulation = 1'b1;
         12: st.battery_present ^= 1'b1;
         default: st.port_detection_status ^= 1'b1;
      endcase
      ent = e;
      @(negedge clk_i);
      ent = '0;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      sys_rst_i = 1'b1;
      rst_cmd = 1'b0;
      flt = '0;
      ent = '0;
      st = '0;
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      @(negedge clk_i);
      rdchk(8'h27, 8'h00);
      rdchk(8'h28, 8'h00);
      rdchk(8'h29, 8'h00);
      u_host.wr(8'h28, 8'hA5);
      rdchk(8'h28, 8'hA5);
      u_host.wr(8'h29, 8'hFF);
      rdchk(8'h29, 8'hD7);
      u_host.wr(8'h27, 8'hFF);
      rdchk(8'h27, 8'h00);
      u_host.wr(8'h30, 8'hFF);
      rdchk(8'h30, 8'h00);
      $display("register access done");
      for (int k = 0; k < 14; k++) begin
         b = k < 8 ? 7 - k : mb1[k-8];
         u_host.wr(8'h28, 8'hFF);
         u_host.wr(8'h29, 8'hFF);
         n = pulses;
         fire(k);
         repeat (12) @(negedge clk_i);
         chk(8'(pulses - n), 8'h00);
         u_host.wr(k < 8 ? 8'h28 : 8'h29, ~(8'h01 << b));
         n = pulses;
         fire(k);
         repeat (12) @(negedge clk_i);
         chk(8'(pulses - n), 8'h01);
      end
      $display("mask gating done");
      @(negedge clk_i);
      rst_cmd = 1'b1;
      @(negedge clk_i);
      rst_cmd = 1'b0;
      rdchk(8'h28, 8'h00);
      rdchk(8'h29, 8'h00);
      n = pulses;
      @(negedge clk_i);
      st.power_good_indication ^= 1'b1;
      st.first_input_present ^= 1'b1;
      st.second_input_present ^= 1'b1;
      st.battery_present ^= 1'b1;
      ent.input_current_limit_state = 1'b1;
      ent.source_mode_current_regulation = 1'b1;
      ent.source_mode_voltage_regulation = 1'b1;
      ent.die_thermal_regulation = 1'b1;
      @(negedge clk_i);
      ent = '0;
      repeat (40) @(negedge clk_i);
      chk(8'(pulses - n), 8'h07);
      $display("reset command and queueing done");
      for (int j = 0; j < 5; j++) begin
         n = pulses;
         @(negedge clk_i);
         flt = cfi_fault_s'(5'b10000 >> j);
         repeat (3) @(negedge clk_i);
         rdchk(8'h27, fx[j]);
         rdchk(8'h27, 8'h00);
         flt = '0;
         chk(8'(pulses - n), 8'h00);
      end
      $display("fault flags done");
      end_sim();
   end
endmodule // cfi_top_tb
